/* hw/sioa_pkg.sv */
// Constants shared by the serial I/O expander with change alert.
// Assumes a 10 MHz core clock and a separate link clock that oversamples the two-wire bus.
package sioa_pkg;

  localparam int PORT_W = 8;

  // Fixed upper bits of the seven-bit target address.
  localparam logic [3:0] ADDR_HI = 4'h4;

  // Register select codes carried in the low two bits of the command byte.
  localparam logic [1:0] SEL_INPUT = 2'h0;
  localparam logic [1:0] SEL_OUTPUT = 2'h1;
  localparam logic [1:0] SEL_POLARITY = 2'h2;
  localparam logic [1:0] SEL_DIRECTION = 2'h3;

  // Reset values of the writable registers.
  localparam logic [7:0] OUTPUT_RST = 8'hFF;
  localparam logic [7:0] POLARITY_RST = 8'h00;
  localparam logic [7:0] DIRECTION_RST = 8'hFF;

  // Alert timing: times as printed, and the core clock cycles they allow.
  localparam int CLK_PERIOD_NS = 100;
  localparam int ALERT_VALID_DELAY_US = 4;
  localparam int ALERT_CLEAR_DELAY_US = 4;
  localparam int ALERT_VALID_CYC = (ALERT_VALID_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int ALERT_CLEAR_CYC = (ALERT_CLEAR_DELAY_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    SIOA_IDLE,
    SIOA_ADDR,
    SIOA_ADDR_ACK,
    SIOA_CMD,
    SIOA_CMD_ACK,
    SIOA_WDATA,
    SIOA_WDATA_ACK,
    SIOA_TX,
    SIOA_TX_ACK
  } sioa_state_t;

endpackage

/* hw/sioa_top.sv */
// Eight-bit I/O expander: two-wire bus target, four registers, open-drain change alert.
// Assumes scl and sda come from an open-drain bus with pull-ups and the pads resolve the enables.
//
// Function
// - Alert low while any input pin differs snapshot.
// - Alert valid within four microseconds of edge.
// - Alert clears on pins returning or input read.
// - Read clear happens at acknowledge clock rise.
// - Change during acknowledge pulse may be lost.
// - Later changes after clear raise alert again.
// - Other targets' transfers and outputs never alert.
// - Output turned input may raise an alert.
// - Alert only pulls low or floats.
// - Input pins undriven; output pins follow register.
// - Reset loads defaults and idles bus machine.
// - All pins are inputs after power-on.
// - Polarity bits invert reported input bits.
// - Every register readable over the bus.
// - Three straps set low address bits.
// - Start, address MSB first, direction, stop.
// - Acknowledge own address holding SDA low.
// - SDA changes only while SCL low.
// - Each byte followed by one acknowledge bit.
// - Release SDA after controller's final no-acknowledge.
// - Command low bits select one of four registers.
// - Direction one means input, zero means output.
// - Register pointer never auto-increments.
// - Address is base 0x20 plus straps.
`timescale 1ns/1ps
`default_nettype none

module sioa_top (
  // Core clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link clock that oversamples the two-wire bus.
  input wire logic link_clk,
  // Two-wire bus.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address straps.
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  // Port pins.
  input wire logic [sioa_pkg::PORT_W-1:0] port_pins_i,
  output logic [sioa_pkg::PORT_W-1:0] port_pins_o,
  output logic [sioa_pkg::PORT_W-1:0] port_pins_oe,
  // Open-drain change alert, active low.
  output logic alert_n_o,
  output logic alert_n_oe
);
  import sioa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain state.

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    sioa_state_t st;
    logic [2:0] bitcnt;
    logic done;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic [1:0] ptr;
    logic nack;
    logic sda_oe;
    logic [7:0] outr;
    logic [7:0] polr;
    logic [7:0] dirr;
    logic wr_tgl;
    logic clr_tgl;
    logic pub_s1;
    logic pub_s2;
    logic ack_tgl;
    logic [7:0] in_word;
  } sioa_link_t;

  sioa_link_t l_r;
  sioa_link_t l_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain state.

  typedef struct packed {
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] snap;
    logic snap_ok;
    logic [7:0] out_c;
    logic [7:0] pol_c;
    logic [7:0] dir_c;
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic clr_s1;
    logic clr_s2;
    logic clr_s3;
    logic ack_s1;
    logic ack_s2;
    logic pub_tgl;
    logic [7:0] pub_word;
    logic alert;
    logic [7:0] drv_o;
    logic [7:0] drv_oe;
    logic [1:0] warm;
    logic [7:0] in_m1;
    logic [7:0] in_m2;
  } sioa_core_t;

  sioa_core_t c_r;
  sioa_core_t c_nxt;

  // Selects the register addressed by the pointer for a read.
  function automatic logic [7:0] sioa_rd_mux(input logic [1:0] sel, input sioa_link_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      SEL_INPUT: v = s.in_word;
      SEL_OUTPUT: v = s.outr;
      SEL_POLARITY: v = s.polr;
      SEL_DIRECTION: v = s.dirr;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus target on the link clock.

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [6:0] own_addr;
  logic [7:0] rd_word;

  always_comb begin
    l_nxt = l_r;
    l_nxt.scl_s1 = scl_i;
    l_nxt.scl_s2 = l_r.scl_s1;
    l_nxt.scl_s3 = l_r.scl_s2;
    l_nxt.sda_s1 = sda_i;
    l_nxt.sda_s2 = l_r.sda_s1;
    l_nxt.sda_s3 = l_r.sda_s2;
    l_nxt.strap_s1 = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    l_nxt.strap_s2 = l_r.strap_s1;
    l_nxt.pub_s1 = c_r.pub_tgl;
    l_nxt.pub_s2 = l_r.pub_s1;
    scl_rise = l_r.scl_s2 & ~l_r.scl_s3;
    scl_fall = ~l_r.scl_s2 & l_r.scl_s3;
    bus_start = l_r.scl_s2 & l_r.scl_s3 & l_r.sda_s3 & ~l_r.sda_s2;
    bus_stop = l_r.scl_s2 & l_r.scl_s3 & ~l_r.sda_s3 & l_r.sda_s2;
    own_addr = {ADDR_HI, l_r.strap_s2};
    rd_word = sioa_rd_mux(l_r.ptr, l_r);

    // The core publishes the input word by toggle; stable until acknowledged here.
    if (l_r.pub_s2 != l_r.ack_tgl) begin
      l_nxt.in_word = c_r.pub_word;
      l_nxt.ack_tgl = l_r.pub_s2;
    end

    if (bus_start) begin
      l_nxt.st = SIOA_ADDR;
      l_nxt.bitcnt = 3'h0;
      l_nxt.done = 1'b0;
      l_nxt.sda_oe = 1'b0;
    end else if (bus_stop) begin
      l_nxt.st = SIOA_IDLE;
      l_nxt.sda_oe = 1'b0;
    end else begin
      unique case (l_r.st)
        SIOA_IDLE: begin
          l_nxt.sda_oe = 1'b0;
        end
        SIOA_ADDR, SIOA_CMD, SIOA_WDATA: begin
          if (scl_rise) begin
            l_nxt.shreg = {l_r.shreg[6:0], l_r.sda_s2};
            l_nxt.bitcnt = l_r.bitcnt + 3'h1;
            l_nxt.done = (l_r.bitcnt == 3'h7);
          end else if (scl_fall && l_r.done) begin
            l_nxt.done = 1'b0;
            l_nxt.sda_oe = 1'b1;
            if (l_r.st == SIOA_ADDR) begin
              if (l_r.shreg[7:1] == own_addr) begin
                l_nxt.st = SIOA_ADDR_ACK;
              end else begin
                l_nxt.st = SIOA_IDLE;
                l_nxt.sda_oe = 1'b0;
              end
            end else if (l_r.st == SIOA_CMD) begin
              l_nxt.ptr = l_r.shreg[1:0];
              l_nxt.st = SIOA_CMD_ACK;
            end else begin
              l_nxt.st = SIOA_WDATA_ACK;
              if (l_r.ptr == SEL_OUTPUT) begin
                l_nxt.outr = l_r.shreg;
              end
              if (l_r.ptr == SEL_POLARITY) begin
                l_nxt.polr = l_r.shreg;
              end
              if (l_r.ptr == SEL_DIRECTION) begin
                l_nxt.dirr = l_r.shreg;
              end
              if (l_r.ptr != SEL_INPUT) begin
                l_nxt.wr_tgl = ~l_r.wr_tgl;
              end
            end
          end
        end
        SIOA_ADDR_ACK: begin
          if (scl_fall) begin
            l_nxt.bitcnt = 3'h0;
            if (l_r.shreg[0]) begin
              l_nxt.st = SIOA_TX;
              l_nxt.txreg = rd_word;
              l_nxt.sda_oe = ~rd_word[7];
            end else begin
              l_nxt.st = SIOA_CMD;
              l_nxt.sda_oe = 1'b0;
            end
          end
        end
        SIOA_CMD_ACK, SIOA_WDATA_ACK: begin
          if (scl_fall) begin
            l_nxt.st = SIOA_WDATA;
            l_nxt.bitcnt = 3'h0;
            l_nxt.sda_oe = 1'b0;
          end
        end
        SIOA_TX: begin
          if (scl_rise) begin
            l_nxt.bitcnt = l_r.bitcnt + 3'h1;
          end else if (scl_fall) begin
            if (l_r.bitcnt == 3'h0) begin
              l_nxt.st = SIOA_TX_ACK;
              l_nxt.sda_oe = 1'b0;
            end else begin
              l_nxt.txreg = {l_r.txreg[6:0], 1'b0};
              l_nxt.sda_oe = ~l_r.txreg[6];
            end
          end
        end
        SIOA_TX_ACK: begin
          if (scl_rise) begin
            l_nxt.nack = l_r.sda_s2;
            if (l_r.ptr == SEL_INPUT) begin
              l_nxt.clr_tgl = ~l_r.clr_tgl;
            end
          end else if (scl_fall) begin
            l_nxt.bitcnt = 3'h0;
            if (l_r.nack) begin
              l_nxt.st = SIOA_IDLE;
              l_nxt.sda_oe = 1'b0;
            end else begin
              l_nxt.st = SIOA_TX;
              l_nxt.txreg = rd_word;
              l_nxt.sda_oe = ~rd_word[7];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      l_r <= '0;
      l_r.st <= SIOA_IDLE;
      l_r.sda_s1 <= 1'b1;
      l_r.sda_s2 <= 1'b1;
      l_r.sda_s3 <= 1'b1;
      l_r.scl_s1 <= 1'b1;
      l_r.scl_s2 <= 1'b1;
      l_r.scl_s3 <= 1'b1;
      l_r.outr <= OUTPUT_RST;
      l_r.polr <= POLARITY_RST;
      l_r.dirr <= DIRECTION_RST;
    end else begin
      l_r <= l_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins, register copies and alert on the core clock.

  logic [7:0] diff;

  always_comb begin
    c_nxt = c_r;
    c_nxt.pin_s1 = port_pins_i;
    c_nxt.pin_s2 = c_r.pin_s1;
    c_nxt.wr_s1 = l_r.wr_tgl;
    c_nxt.wr_s2 = c_r.wr_s1;
    c_nxt.wr_s3 = c_r.wr_s2;
    c_nxt.clr_s1 = l_r.clr_tgl;
    c_nxt.clr_s2 = c_r.clr_s1;
    c_nxt.clr_s3 = c_r.clr_s2;
    c_nxt.ack_s1 = l_r.ack_tgl;
    c_nxt.ack_s2 = c_r.ack_s1;

    // Register words are stable long before their toggle arrives here.
    if (c_r.wr_s2 != c_r.wr_s3) begin
      c_nxt.out_c = l_r.outr;
      c_nxt.pol_c = l_r.polr;
      c_nxt.dir_c = l_r.dirr;
    end

    if (c_r.pub_tgl == c_r.ack_s2) begin
      c_nxt.pub_word = c_r.pin_s2 ^ c_r.pol_c;
      c_nxt.pub_tgl = ~c_r.pub_tgl;
    end

    // The first snapshot waits until the pin synchroniser holds real pin levels.
    c_nxt.warm = {c_r.warm[0], 1'b1};
    if (!c_r.snap_ok) begin
      c_nxt.snap = c_r.pin_s2;
      c_nxt.snap_ok = c_r.warm[1];
    end else if (c_r.clr_s2 != c_r.clr_s3) begin
      c_nxt.snap = c_r.pin_s2;
    end

    // The input mask follows the pin enables through the same delay as the pins.
    c_nxt.in_m1 = ~c_r.drv_oe;
    c_nxt.in_m2 = c_r.in_m1;
    diff = (c_r.pin_s2 ^ c_nxt.snap) & c_r.in_m2;
    c_nxt.alert = c_r.snap_ok & (|diff);

    c_nxt.drv_o = c_r.out_c;
    c_nxt.drv_oe = ~c_r.dir_c;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_r <= '0;
      c_r.out_c <= OUTPUT_RST;
      c_r.pol_c <= POLARITY_RST;
      c_r.dir_c <= DIRECTION_RST;
      c_r.drv_o <= OUTPUT_RST;
      c_r.in_m1 <= DIRECTION_RST;
      c_r.in_m2 <= DIRECTION_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  assign sda_o = 1'b0;
  assign sda_oe = l_r.sda_oe;
  assign port_pins_o = c_r.drv_o;
  assign port_pins_oe = c_r.drv_oe;
  assign alert_n_o = 1'b0;
  assign alert_n_oe = c_r.alert;

endmodule

`default_nettype wire

/* tb/sioa_bm.sv */
// Bus controller model paced by the link clock.
// Assumes SDA is resolved outside with a pull-up; SCL stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module sioa_bm (
  // Pacing clock and resolved data line.
  input wire logic link_clk,
  input wire logic sda,
  // Clock line and data release, high means released.
  output logic scl,
  output logic sda_rel
);
  int hp_n = 4;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic hp();
    repeat (hp_n) @(posedge link_clk);
  endtask
  task automatic start();
    sda_rel <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_rel <= 1'b0;
    hp();
    scl <= 1'b0;
  endtask
  task automatic stop();
    hp();
    sda_rel <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_rel <= 1'b1;
    hp();
  endtask
  task automatic bit_x(input logic b, output logic r);
    hp();
    sda_rel <= b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic ackm, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ackm, ack);
  endtask
endmodule
`default_nettype wire

/* tb/sioa_chk_assertions.sv */
// Port checks for the I/O expander.
// Assumes it is bound to sioa_top; scl_i is seen in the core domain as a level.
`timescale 1ns/1ps
`default_nettype none
module sioa_chk (
  // Clocks, reset and bus.
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Pins and alert.
  input wire logic [7:0] port_pins_i,
  input wire logic [7:0] port_pins_o,
  input wire logic [7:0] port_pins_oe,
  input wire logic alert_n_o,
  input wire logic alert_n_oe
);
  localparam int LIM = 40;
  logic [7:0] pins_r;
  logic [7:0] oe_r;
  logic [5:0] chg_r;
  logic [5:0] rise_r;
  logic scl_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_r <= 8'h00;
      oe_r <= 8'h00;
      chg_r <= 6'h3F;
      rise_r <= 6'h3F;
      scl_r <= 1'b1;
    end else begin
      pins_r <= port_pins_i;
      oe_r <= port_pins_oe;
      scl_r <= scl_i;
      if (port_pins_i != pins_r || port_pins_oe != oe_r) chg_r <= 6'h00;
      else if (chg_r != 6'h3F) chg_r <= chg_r + 6'h01;
      if (scl_i && !scl_r) rise_r <= 6'h00;
      else if (rise_r != 6'h3F) rise_r <= rise_r + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_alert_od: assert property (@(posedge clk) disable iff (rst) alert_n_o == 1'b0)
    else $error("alert pin driven high");
  chk_sda_od: assert property (@(posedge link_clk) disable iff (rst) sda_o == 1'b0)
    else $error("data line driven high");
  chk_sda_steady: assert property (@(posedge link_clk) disable iff (rst)
    scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("data moved while clock high");
  chk_reset_dir: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> port_pins_oe == 8'h00 && port_pins_o == 8'hFF) else $error("reset pins");
  chk_reset_quiet: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> !alert_n_oe [*3]) else $error("alert after reset");
  chk_alert_valid: assert property (@(posedge clk) disable iff (rst)
    $changed(port_pins_i & ~port_pins_oe) && $stable(port_pins_oe) && !alert_n_oe
    |-> ##[3:LIM] (alert_n_oe || chg_r < 6'h02)) else $error("alert late");
  chk_alert_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(alert_n_oe) |-> chg_r <= 6'h06) else $error("alert without pin change");
  chk_alert_clear: assert property (@(posedge clk) disable iff (rst)
    $fell(alert_n_oe) |-> chg_r <= 6'h06 || rise_r <= 6'h28) else $error("alert cleared idly");
  cov_alert_up: cover property (@(posedge clk) $rose(alert_n_oe));
  cov_alert_down: cover property (@(posedge clk) $fell(alert_n_oe));
  cov_acked: cover property (@(posedge link_clk) $rose(sda_oe));
endmodule
bind sioa_top sioa_chk sioa_chk_inst (.clk(clk), .rst(rst), .link_clk(link_clk),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .port_pins_i(port_pins_i),
  .port_pins_o(port_pins_o), .port_pins_oe(port_pins_oe), .alert_n_o(alert_n_o),
  .alert_n_oe(alert_n_oe));
`default_nettype wire

/* tb/tb.sv */
// Testbench for the I/O expander with change alert.
// Assumes the design, the bus model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sioa_pkg::*;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] strap = 3'h0;
  logic [7:0] ext = 8'h00;
  logic [7:0] dir, pol, v;
  logic [15:0] rv;
  int failures = 0;
  int num_checks = 0;
  int seed = 32'h2420;
  wire logic scl, sda_rel, sda_o, sda_oe, alert_n_o, alert_n_oe;
  wire logic [7:0] po, poe;
  wire logic [7:0] pins = (poe & po) | (~poe & ext);
  wire logic sda = sda_rel & ~(sda_oe & ~sda_o);
  wire logic alert_w = ~(alert_n_oe & ~alert_n_o);
  always #50 clk = ~clk;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  sioa_top sioa_top_inst (.clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .port_pins_i(pins),
    .port_pins_o(po), .port_pins_oe(poe), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe));
  sioa_bm sioa_bm_inst (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_in(input logic [7:0] o, d, p, e);
    return ((~d & o) | (d & e)) ^ p;
  endfunction
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic alert_is(input logic e);
    repeat (ALERT_VALID_CYC) @(posedge clk);
    #1;
    chk1("alert line", ~e, alert_w);
  endtask
  task automatic send_addr(input logic [2:0] a, input logic r);
    logic [7:0] q;
    logic ack;
    sioa_bm_inst.start();
    sioa_bm_inst.byte_x({ADDR_HI, a, r}, 1'b1, q, ack);
    chk1("addr ack", a != strap, ack);
  endtask
  task automatic wr(input logic [1:0] c, input logic [7:0] d);
    logic [7:0] q;
    logic ack;
    send_addr(strap, 1'b0);
    sioa_bm_inst.byte_x({d[5:0], c}, 1'b1, q, ack);
    sioa_bm_inst.byte_x(~d, 1'b1, q, ack);
    sioa_bm_inst.byte_x(d, 1'b1, q, ack);
    chk1("data ack", 1'b0, ack);
    sioa_bm_inst.stop();
  endtask
  task automatic rd(input logic [1:0] c, output logic [15:0] r);
    logic ack;
    send_addr(strap, 1'b0);
    sioa_bm_inst.byte_x({6'h2A, c}, 1'b1, r[7:0], ack);
    send_addr(strap, 1'b1);
    sioa_bm_inst.byte_x(8'hFF, 1'b0, r[15:8], ack);
    sioa_bm_inst.byte_x(8'hFF, 1'b1, r[7:0], ack);
    sioa_bm_inst.stop();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #8000000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge link_clk);
    chk8("pin enables", 8'h00, poe);
    chk8("pin outputs", OUTPUT_RST, po);
    chk1("alert line", 1'b1, alert_w);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      strap <= s[2:0];
      @(posedge clk);
      send_addr(s[2:0] ^ 3'h5, 1'b1);
      sioa_bm_inst.stop();
      rd(SEL_DIRECTION, rv);
      chk8("direction", DIRECTION_RST, rv[7:0]);
      chk8("reread", DIRECTION_RST, rv[15:8]);
    end
    rd(SEL_POLARITY, rv);
    chk8("polarity", POLARITY_RST, rv[7:0]);
    $display("test reset and address done");
    repeat (4) begin
      dir = 8'($random(seed));
      pol = 8'($random(seed));
      v = 8'($random(seed));
      wr(SEL_OUTPUT, v);
      wr(SEL_DIRECTION, dir);
      wr(SEL_POLARITY, pol);
      wr(SEL_INPUT, ~v);
      repeat (8) @(posedge clk);
      chk8("pin enables", ~dir, poe);
      chk8("pin outputs", v, po);
      rd(SEL_OUTPUT, rv);
      chk8("output reg", v, rv[7:0]);
      rd(SEL_INPUT, rv);
      chk8("input reg", exp_in(v, dir, pol, ext), rv[7:0]);
      rd(SEL_POLARITY, rv);
      chk8("polarity reg", pol, rv[15:8]);
      rd(SEL_DIRECTION, rv);
      chk8("direction reg", dir, rv[7:0]);
    end
    $display("test registers done");
    wr(SEL_DIRECTION, 8'hF0);
    rd(SEL_INPUT, rv);
    alert_is(1'b0);
    for (int b = 0; b < 8; b++) begin
      @(posedge clk);
      ext[b] <= ~ext[b];
      alert_is(b > 3);
      @(posedge clk);
      ext[b] <= ~ext[b];
      alert_is(1'b0);
    end
    @(posedge clk);
    ext <= ext ^ 8'h80;
    alert_is(1'b1);
    send_addr(strap ^ 3'h1, 1'b1);
    sioa_bm_inst.stop();
    alert_is(1'b1);
    sioa_bm_inst.hp_n = 7;
    rd(SEL_INPUT, rv);
    sioa_bm_inst.hp_n = 4;
    chk8("input reg", exp_in(v, 8'hF0, pol, ext), rv[7:0]);
    alert_is(1'b0);
    @(posedge clk);
    ext <= ext ^ 8'h40;
    alert_is(1'b1);
    $display("test alert done");
    wrap_up();
  end
endmodule
`default_nettype wire
